//--- logic/tzcb_defines.svh
// Register map, field positions, reset values and code points for the timer
`ifndef TZCB_DEFINES_SVH
`define TZCB_DEFINES_SVH

// ------------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------------
`define TZCB_OFS_CTRL      8'h00
`define TZCB_OFS_REF       8'h04
`define TZCB_OFS_COUNT     8'h08
`define TZCB_OFS_FLAGS     8'h0c
`define TZCB_OFS_BUF       8'h10

// ------------------------------------------------------------------
// Control register fields
// ------------------------------------------------------------------
`define TZCB_CTRL_SPARE    7
`define TZCB_CTRL_MODE_HI  6
`define TZCB_CTRL_MODE_LO  5
`define TZCB_CTRL_CLR      4
`define TZCB_CTRL_CS_HI    3
`define TZCB_CTRL_CS_LO    0

// ------------------------------------------------------------------
// Flag register fields
// ------------------------------------------------------------------
`define TZCB_FLAG_OVF      0
`define TZCB_FLAG_MATCH    1

// ------------------------------------------------------------------
// Reset values and constants
// ------------------------------------------------------------------
`define TZCB_RST_BYTE      8'h00
`define TZCB_CNT_TOP       8'hff
`define TZCB_CNT_ONE       8'h01
`define TZCB_RD_ZERO       32'h0000_0000
`define TZCB_PRE_ONE       11'h001

// ------------------------------------------------------------------
// Prescaler shift per internal clock code (low three select bits)
// ------------------------------------------------------------------
`define TZCB_SH_DIV2       4'h1
`define TZCB_SH_DIV4       4'h2
`define TZCB_SH_DIV8       4'h3
`define TZCB_SH_DIV16      4'h4
`define TZCB_SH_DIV32      4'h5
`define TZCB_SH_DIV128     4'h7
`define TZCB_SH_DIV512     4'h9
`define TZCB_SH_DIV2048    4'hb

`endif

//--- logic/tzcb_pkg.sv
// Types shared by the timer control blocks
package tzcb_pkg;

    // Clock-source codes of the control register
    typedef enum logic [3:0] {
        TZCB_CS_STOP   = 4'h0,
        TZCB_CS_RES1   = 4'h1,
        TZCB_CS_RES2   = 4'h2,
        TZCB_CS_RES3   = 4'h3,
        TZCB_CS_RES4   = 4'h4,
        TZCB_CS_EXT_R  = 4'h5,
        TZCB_CS_EXT_F  = 4'h6,
        TZCB_CS_RES7   = 4'h7,
        TZCB_CS_DIV2   = 4'h8,
        TZCB_CS_DIV4   = 4'h9,
        TZCB_CS_DIV8   = 4'ha,
        TZCB_CS_DIV16  = 4'hb,
        TZCB_CS_DIV32  = 4'hc,
        TZCB_CS_DIV128 = 4'hd,
        TZCB_CS_DIV512 = 4'he,
        TZCB_CS_DIV2K  = 4'hf
    } tzcb_cs_e;

    // Operating modes, Gray ordered
    typedef enum logic [1:0] {
        TZCB_MODE_INTERVAL = 2'h0,
        TZCB_MODE_PWM      = 2'h1,
        TZCB_MODE_CAPT_A   = 2'h3,
        TZCB_MODE_CAPT_B   = 2'h2
    } tzcb_mode_e;

endpackage

//--- logic/tzcb_prescale.sv
// Free-running divider of the system clock with a selectable tick
`timescale 1ns/1ps
`include "tzcb_defines.svh"

module tzcb_prescale #(
    parameter int W = 11                // Divider width, covers /2048
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [2:0]  sel,
    output logic             tick
);
    import tzcb_pkg::*;

    logic [W-1:0] div_ff;               // Divider count
    logic [W-1:0] mask;                 // Low bits that must be all ones
    logic [3:0]   shift;                // Log2 of the divide ratio
    logic         tick_ff;              // One pulse per divided period

    // ------------------------------------------------------------------
    // Divide ratio lookup
    // ------------------------------------------------------------------
    always_comb begin
        unique case (sel)
            3'h0: shift = `TZCB_SH_DIV2;
            3'h1: shift = `TZCB_SH_DIV4;
            3'h2: shift = `TZCB_SH_DIV8;
            3'h3: shift = `TZCB_SH_DIV16;
            3'h4: shift = `TZCB_SH_DIV32;
            3'h5: shift = `TZCB_SH_DIV128;
            3'h6: shift = `TZCB_SH_DIV512;
            3'h7: shift = `TZCB_SH_DIV2048;
        endcase
        mask = W'((W'(1) << shift) - W'(1));
    end

    // ------------------------------------------------------------------
    // Counter runs always so ratio changes take effect at once
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_ff <= '0;
        end else begin
            div_ff <= div_ff + W'(1);
        end
    end

    // Tick registered; a ratio change may give one short period
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_ff <= 1'b0;
        end else begin
            tick_ff <= ((div_ff & mask) == mask);
        end
    end

    assign tick = tick_ff;

endmodule // tzcb_prescale

//--- logic/tzcb_edge.sv
// Edge detector for the external count pin
`timescale 1ns/1ps

module tzcb_edge (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic pin,
    output logic      rise,
    output logic      fall
);
    import tzcb_pkg::*;

    logic prev_ff;                      // Pin level one clock ago
    logic rise_ff;                      // Rising edge pulse
    logic fall_ff;                      // Falling edge pulse

    // ------------------------------------------------------------------
    // Pin is synchronous; compare with last sample
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_ff <= 1'b0;
            rise_ff <= 1'b0;
            fall_ff <= 1'b0;
        end else begin
            prev_ff <= pin;
            rise_ff <= pin & ~prev_ff;
            fall_ff <= ~pin & prev_ff;
        end
    end

    assign rise = rise_ff;
    assign fall = fall_ff;

endmodule // tzcb_edge

//--- logic/tzcb_timer.sv
// Timer clock select, counter clear and compare buffer with APB registers
`timescale 1ns/1ps
`include "tzcb_defines.svh"

module tzcb_timer (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        external_count_pin,
    input  wire logic        match_service_ack,
    input  wire logic        ovf_service_ack,
    output logic             match_request_flag,
    output logic             overflow_request_flag,
    output logic [7:0]       count_value
);
    import tzcb_pkg::*;

    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------
    logic        spare_ff;              // Unused control bit, kept R/W
    tzcb_mode_e  mode_ff;               // Operating mode
    logic        clr_ff;                // Pending counter-clear command
    tzcb_cs_e    cs_ff;                 // Count clock select
    logic [7:0]  ref_ff;                // Software compare reference
    logic [7:0]  buf_ff;                // Compare buffer seen by comparator
    logic [7:0]  cnt_ff;                // Timer counter
    logic        match_ff;              // Match request flag
    logic        ovf_ff;                // Overflow request flag
    logic [31:0] prdata_ff;             // Read data
    logic        pready_ff;             // Access-phase ready
    logic        pslverr_ff;            // Unmapped address error

    // ------------------------------------------------------------------
    // Combinational helpers
    // ------------------------------------------------------------------
    logic        pre_tick;              // Prescaler tick
    logic        pin_rise;              // Pin rising edge
    logic        pin_fall;              // Pin falling edge
    logic        cnt_tick;              // Counter advance strobe
    logic        match_ev;              // Counter equals buffer on a tick
    logic        ovf_ev;                // Counter wraps on a tick
    logic        wr_go;                 // Write takes effect this edge
    logic        mapped;                // Address hits a register
    logic [7:0]  ctrl_rd;               // Control register as read
    logic [31:0] nxt_prdata;            // Read data for the decoded address

    // ------------------------------------------------------------------
    // Clock sources
    // ------------------------------------------------------------------
    tzcb_prescale #(
        .W (11)
    ) u_pre (
        .pclk    (pclk),
        .presetn (presetn),
        .sel     (cs_ff[2:0]),
        .tick    (pre_tick)
    );

    tzcb_edge u_edge (
        .pclk    (pclk),
        .presetn (presetn),
        .pin     (external_count_pin),
        .rise    (pin_rise),
        .fall    (pin_fall)
    );

    // Select the counting strobe from the clock-source code
    always_comb begin
        unique case (cs_ff)
            TZCB_CS_EXT_R:  cnt_tick = pin_rise;
            TZCB_CS_EXT_F:  cnt_tick = pin_fall;
            TZCB_CS_DIV2, TZCB_CS_DIV4, TZCB_CS_DIV8, TZCB_CS_DIV16,
            TZCB_CS_DIV32, TZCB_CS_DIV128, TZCB_CS_DIV512,
            TZCB_CS_DIV2K:  cnt_tick = pre_tick;
            // Stop and reserved codes give no clock
            default:        cnt_tick = 1'b0;
        endcase
    end

    // ------------------------------------------------------------------
    // Compare and overflow events
    // ------------------------------------------------------------------
    // Comparator looks only at the buffer, so a reference write cannot
    // disturb the period that is running
    always_comb begin
        match_ev = 1'b0;
        ovf_ev   = 1'b0;
        if (cnt_tick && !clr_ff) begin
            unique case (mode_ff)
                TZCB_MODE_INTERVAL,
                TZCB_MODE_PWM: begin
                    match_ev = (cnt_ff == buf_ff);
                    ovf_ev   = (cnt_ff == `TZCB_CNT_TOP) && !(
                        mode_ff == TZCB_MODE_INTERVAL && match_ev);
                end
                TZCB_MODE_CAPT_A,
                TZCB_MODE_CAPT_B: begin
                    ovf_ev   = (cnt_ff == `TZCB_CNT_TOP);
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_ff <= `TZCB_RST_BYTE;
        end else if (clr_ff) begin
            // Clear command wins over counting
            cnt_ff <= `TZCB_RST_BYTE;
        end else if (match_ev && mode_ff == TZCB_MODE_INTERVAL) begin
            // Interval mode restarts at each match
            cnt_ff <= `TZCB_RST_BYTE;
        end else if (cnt_tick) begin
            cnt_ff <= cnt_ff + `TZCB_CNT_ONE;
        end
    end

    // ------------------------------------------------------------------
    // Compare buffer
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            buf_ff <= `TZCB_RST_BYTE;
        end else if (clr_ff || ovf_ev || match_ev) begin
            buf_ff <= ref_ff;
        end
    end

    // ------------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------------
    assign wr_go = psel && penable && pready_ff && pwrite;

    always_comb begin
        ctrl_rd = {spare_ff, mode_ff, clr_ff, cs_ff};
        mapped  = 1'b1;
        unique case (paddr)
            `TZCB_OFS_CTRL:  nxt_prdata = {24'h000000, ctrl_rd};
            `TZCB_OFS_REF:   nxt_prdata = {24'h000000, ref_ff};
            `TZCB_OFS_COUNT: nxt_prdata = {24'h000000, cnt_ff};
            `TZCB_OFS_FLAGS: nxt_prdata = {30'h0, match_ff, ovf_ff};
            `TZCB_OFS_BUF:   nxt_prdata = {24'h000000, buf_ff};
            default: begin
                nxt_prdata = `TZCB_RD_ZERO;
                mapped     = 1'b0;
            end
        endcase
    end

    // Ready and error are raised in setup so every access is one cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
        end else begin
            pready_ff  <= psel && !penable;
            pslverr_ff <= psel && !penable && !mapped;
        end
    end

    // Read data captured in setup, held through the access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff <= `TZCB_RD_ZERO;
        end else if (psel && !penable && !pwrite) begin
            prdata_ff <= nxt_prdata;
        end
    end

    // ------------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            spare_ff <= 1'b0;
            mode_ff  <= TZCB_MODE_INTERVAL;
            cs_ff    <= TZCB_CS_STOP;
        end else if (wr_go && paddr == `TZCB_OFS_CTRL) begin
            spare_ff <= pwdata[`TZCB_CTRL_SPARE];
            mode_ff  <= tzcb_mode_e'(
                pwdata[`TZCB_CTRL_MODE_HI:`TZCB_CTRL_MODE_LO]);
            cs_ff    <= tzcb_cs_e'(pwdata[`TZCB_CTRL_CS_HI:`TZCB_CTRL_CS_LO]);
        end
    end

    // Clear bit lives one cycle; writing zero leaves it alone
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clr_ff <= 1'b0;
        end else if (wr_go && paddr == `TZCB_OFS_CTRL &&
                     pwdata[`TZCB_CTRL_CLR]) begin
            clr_ff <= 1'b1;
        end else begin
            clr_ff <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Reference data register
    // ------------------------------------------------------------------
    // Software must load this before the clear command, since the clear
    // copies it into the buffer, as a match or an overflow also does
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ref_ff <= `TZCB_RST_BYTE;
        end else if (wr_go && paddr == `TZCB_OFS_REF) begin
            ref_ff <= pwdata[7:0];
        end
    end

    // ------------------------------------------------------------------
    // Request flags: set beats any clear in the same cycle
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            match_ff <= 1'b0;
        end else if (match_ev) begin
            match_ff <= 1'b1;
        end else if (match_service_ack) begin
            match_ff <= 1'b0;
        end else if (wr_go && paddr == `TZCB_OFS_FLAGS &&
                     pwdata[`TZCB_FLAG_MATCH]) begin
            match_ff <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ovf_ff <= 1'b0;
        end else if (ovf_ev) begin
            ovf_ff <= 1'b1;
        end else if (ovf_service_ack) begin
            ovf_ff <= 1'b0;
        end else if (wr_go && paddr == `TZCB_OFS_FLAGS &&
                     pwdata[`TZCB_FLAG_OVF]) begin
            ovf_ff <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Outputs, all straight from flip-flops
    // ------------------------------------------------------------------
    assign prdata                = prdata_ff;
    assign pready                = pready_ff;
    assign pslverr               = pslverr_ff;
    assign match_request_flag    = match_ff;
    assign overflow_request_flag = ovf_ff;
    assign count_value           = cnt_ff;

endmodule // tzcb_timer

//--- test/tzcb_timer_properties.sv
// Checker for the timer bus handshake, counter steps and request flags
`timescale 1ns/1ps
`include "tzcb_defines.svh"

module tzcb_timer_checker (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        external_count_pin,
    input wire logic        match_service_ack,
    input wire logic        ovf_service_ack,
    input wire logic        match_request_flag,
    input wire logic        overflow_request_flag,
    input wire logic [7:0]  count_value
);
    // ------------------------------------------------------------
    // Helper terms
    // ------------------------------------------------------------
    logic setup;   // Setup phase of a transfer
    logic mapped;  // Address hits one of the five registers
    logic flag_wr; // Access phase of a write to the flag register
    assign setup   = psel && !penable;
    assign mapped  = paddr inside {`TZCB_OFS_CTRL, `TZCB_OFS_REF,
                     `TZCB_OFS_COUNT, `TZCB_OFS_FLAGS, `TZCB_OFS_BUF};
    assign flag_wr = psel && penable && pwrite &&
                     (paddr == `TZCB_OFS_FLAGS);

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    property p_ready_after_setup;
        setup |=> pready;
    endproperty
    property p_ready_in_access;
        pready |-> psel && penable && $past(setup);
    endproperty
    property p_ready_pulse;
        pready |=> !pready;
    endproperty
    property p_err_unmapped;
        pready |-> (pslverr == !mapped);
    endproperty
    property p_err_read_zero;
        pready && pslverr && !pwrite |-> prdata == 32'h0000_0000;
    endproperty
    // Counter only steps by one or returns to zero
    property p_count_step;
        count_value != $past(count_value) |->
            count_value == $past(count_value) + 8'h01 ||
            count_value == 8'h00;
    endproperty
    property p_ovf_rise;
        $rose(overflow_request_flag) |->
            count_value == 8'h00 && $past(count_value) == 8'hff;
    endproperty
    // A new match event is only possible when the counter moved or is at zero
    property p_match_ack;
        match_service_ack && !flag_wr |=> !match_request_flag ||
            count_value != $past(count_value) || count_value == 8'h00;
    endproperty
    property p_match_hold;
        match_request_flag && !match_service_ack && !flag_wr |=>
            match_request_flag;
    endproperty
    property p_ovf_hold;
        overflow_request_flag && !ovf_service_ack && !flag_wr |=>
            overflow_request_flag;
    endproperty

    a_ready_after_setup: assert property (p_ready_after_setup)
        else $error("pready missing after setup");
    a_ready_in_access: assert property (p_ready_in_access)
        else $error("pready outside access phase");
    a_ready_pulse: assert property (p_ready_pulse)
        else $error("pready longer than one cycle");
    a_err_unmapped: assert property (p_err_unmapped)
        else $error("pslverr does not match address map");
    a_err_read_zero: assert property (p_err_read_zero)
        else $error("refused read returned data");
    a_count_step: assert property (p_count_step)
        else $error("counter jumped");
    a_ovf_rise: assert property (p_ovf_rise)
        else $error("overflow flag without wrap");
    a_match_ack: assert property (p_match_ack)
        else $error("match flag kept after service");
    a_match_hold: assert property (p_match_hold)
        else $error("match flag lost");
    a_ovf_hold: assert property (p_ovf_hold)
        else $error("overflow flag lost");

    c_write: cover property (pready && pwrite && !pslverr);
    c_match: cover property ($rose(match_request_flag));
    c_ovf: cover property ($rose(overflow_request_flag));
    c_pin_step: cover property ($rose(external_count_pin) ##2
        count_value != $past(count_value));

endmodule // tzcb_timer_checker

bind tzcb_timer tzcb_timer_checker u_tzcb_timer_checker (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr),
    .external_count_pin(external_count_pin),
    .match_service_ack(match_service_ack),
    .ovf_service_ack(ovf_service_ack),
    .match_request_flag(match_request_flag),
    .overflow_request_flag(overflow_request_flag),
    .count_value(count_value)
);

//--- test/tb.sv
// Self-checking bench for the timer clock select and compare buffer
`timescale 1ns/1ps
`include "tzcb_defines.svh"

module tb;
    import tzcb_pkg::*;

    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic        pclk, presetn, psel, penable, pwrite;
    logic [7:0]  paddr, count_value;
    logic [31:0] pwdata, prdata, rd;
    logic        pready, pslverr, ext_pin, m_ack, o_ack;
    logic        m_flag, o_flag;
    int          bad_count, num_checks, cyc;
    int          div_tab[8] = '{2, 4, 8, 16, 32, 128, 512, 2048};
    logic [3:0]  res_tab[5] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h7};

    tzcb_timer u_tzcb_timer (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .external_count_pin(ext_pin), .match_service_ack(m_ack),
        .ovf_service_ack(o_ack), .match_request_flag(m_flag),
        .overflow_request_flag(o_flag), .count_value(count_value));

    // 100 ns period clock
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    // Watchdog on the whole run, well above the slowest divider test
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            bad_count++;
            stop_test();
        end
    end

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic stop_test();
        if (bad_count == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
        num_checks++;
        if (got !== exp) begin
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
            bad_count++;
        end
    endtask

    // One APB transfer; request held until pready is seen high
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Only the bench watchdog ends a wait that never sees pready
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        chk({31'h0, pslverr}, {31'h0, !(a inside {8'h00, 8'h04, 8'h08,
            8'h0c, 8'h10})}, "slave error");
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        chk(rd, exp, "read data");
    endtask

    // Full pin period; both edges are spaced well apart
    task automatic pulse_pin(input int n);
        repeat (n) begin
            ext_pin <= 1'b1;
            repeat (4) @(posedge pclk);
            ext_pin <= 1'b0;
            repeat (4) @(posedge pclk);
        end
    endtask

    // Wait for a flag under a bound; a missing flag is a mismatch
    task automatic wait_flag(ref logic f, input int lim);
        int n;
        n = 0;
        while (f !== 1'b1 && n < lim) begin
            @(posedge pclk);
            n++;
        end
        chk({31'h0, f}, 32'h1, "flag timeout");
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        int n;
        logic [7:0] mx;
        {psel, penable, pwrite, ext_pin, m_ack, o_ack} = '0;
        paddr = 8'h00;
        pwdata = 32'h0;
        presetn = 1'b0;
        bad_count = 0;
        num_checks = 0;
        cyc = 0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        // Reset values and the unmapped place
        for (int i = 0; i <= 8'h14; i += 4) rd_chk(i[7:0], 32'h0);
        xfer(1'b1, 8'h20, 32'h0000_00ff);
        // Buffer loads on clear, not on a reference write; comparator uses the buffer
        xfer(1'b1, `TZCB_OFS_REF, 32'h3);
        rd_chk(`TZCB_OFS_BUF, 32'h0);
        xfer(1'b1, `TZCB_OFS_CTRL, 32'h10);
        rd_chk(`TZCB_OFS_BUF, 32'h3);
        rd_chk(`TZCB_OFS_COUNT, 32'h0);
        rd_chk(`TZCB_OFS_CTRL, 32'h0);
        // Spare bit and mode codes 3 and 1 read back
        xfer(1'b1, `TZCB_OFS_CTRL, 32'he0);
        rd_chk(`TZCB_OFS_CTRL, 32'he0);
        xfer(1'b1, `TZCB_OFS_CTRL, 32'h20);
        rd_chk(`TZCB_OFS_CTRL, 32'h20);
        xfer(1'b1, `TZCB_OFS_REF, 32'h5);
        xfer(1'b1, `TZCB_OFS_CTRL, 32'h08);
        mx = 8'h00;
        for (n = 0; n < 100 && m_flag !== 1'b1; n++) begin
            @(posedge pclk);
            if (count_value > mx) mx = count_value;
        end
        chk({24'h0, mx}, 32'h3, "match point");
        chk({31'h0, m_flag}, 32'h1, "match flag");
        rd_chk(`TZCB_OFS_BUF, 32'h5);
        // Stop the count first so no new match races the service pulse
        xfer(1'b1, `TZCB_OFS_CTRL, 32'h00);
        m_ack <= 1'b1;
        @(posedge pclk);
        m_ack <= 1'b0;
        @(posedge pclk);
        chk({31'h0, m_flag}, 32'h0, "match ack");
        // Zero in the clear bit leaves the counter alone
        xfer(1'b0, `TZCB_OFS_COUNT, 32'h0);
        mx = rd[7:0];
        xfer(1'b1, `TZCB_OFS_CTRL, 32'h00);
        rd_chk(`TZCB_OFS_COUNT, {24'h0, mx});
        xfer(1'b1, `TZCB_OFS_CTRL, 32'h10);
        rd_chk(`TZCB_OFS_COUNT, 32'h0);
        // External pin edges
        xfer(1'b1, `TZCB_OFS_REF, 32'hff);
        xfer(1'b1, `TZCB_OFS_CTRL, 32'h15);
        pulse_pin(3);
        // End high: a fourth rise but no fourth fall
        ext_pin <= 1'b1;
        repeat (4) @(posedge pclk);
        rd_chk(`TZCB_OFS_COUNT, 32'h4);
        // Zero in the clear bit keeps a nonzero count
        xfer(1'b1, `TZCB_OFS_CTRL, 32'h05);
        rd_chk(`TZCB_OFS_COUNT, 32'h4);
        xfer(1'b1, `TZCB_OFS_CTRL, 32'h16);
        pulse_pin(3);
        rd_chk(`TZCB_OFS_COUNT, 32'h3);
        // Reserved codes give no counter clock
        foreach (res_tab[i]) begin
            xfer(1'b1, `TZCB_OFS_CTRL, {27'h0, 1'b1, res_tab[i]});
            pulse_pin(2);
            rd_chk(`TZCB_OFS_COUNT, 32'h0);
        end
        // Divided system clock: measure one counter step, from count 1 to count 2
        for (int c = 0; c < 8; c++) begin
            xfer(1'b1, `TZCB_OFS_CTRL, 32'h18 + c);
            for (n = 0; n < 5000 && count_value !== 8'h01; n++)
                @(posedge pclk);
            for (n = 0; n < 5000 && count_value !== 8'h02; n++)
                @(posedge pclk);
            chk(n, div_tab[c], "divider period");
        end
        // Capture B mode: buffer reload on overflow, both flag clears
        xfer(1'b1, `TZCB_OFS_CTRL, 32'h58);
        xfer(1'b1, `TZCB_OFS_REF, 32'h44);
        wait_flag(o_flag, 700);
        rd_chk(`TZCB_OFS_BUF, 32'h44);
        rd_chk(`TZCB_OFS_FLAGS, 32'h1);
        xfer(1'b1, `TZCB_OFS_FLAGS, 32'h1);
        rd_chk(`TZCB_OFS_FLAGS, 32'h0);
        wait_flag(o_flag, 700);
        o_ack <= 1'b1;
        @(posedge pclk);
        o_ack <= 1'b0;
        @(posedge pclk);
        chk({31'h0, o_flag}, 32'h0, "overflow ack");
        stop_test();
    end

endmodule // tb
